// File: fas_pkg.sv
// fas_pkg: constants for the autoselect identification readout controller.
// assumes a 100 MHz controller clock and a 32-Mbit x16 parallel flash on the far side.
`default_nettype none
package fas_pkg;
  // ==========================================================================
  // widths
  localparam int ADDR_W = 21;                     // word address bits A20..A0
  localparam int DATA_W = 16;
  localparam int BANK_LSB = 18;                   // bank address on A20..A18
  localparam int SECT_LSB = 12;                   // sector address on A20..A12
  // ==========================================================================
  // timing, figures in ns, counts derived for the 10 ns clock
  localparam int CLK_NS = 10;
  localparam int T_WP_NS = 40;                    // write pulse low time
  localparam int T_ACC_NS = 70;                   // read access time
  localparam int T_GAP_NS = 30;                   // recovery between cycles
  localparam int T_HV_NS = 500;                   // settle of the high id level on A9
  localparam int T_WP_CYC = (T_WP_NS + CLK_NS - 1) / CLK_NS;
  localparam int T_ACC_CYC = (T_ACC_NS + CLK_NS - 1) / CLK_NS + 2; // plus two sync flops
  localparam int T_GAP_CYC = (T_GAP_NS + CLK_NS - 1) / CLK_NS;
  localparam int T_HV_CYC = (T_HV_NS + CLK_NS - 1) / CLK_NS;
  // ==========================================================================
  // command register sequence, plain unlock pattern
  localparam logic [ADDR_W-1:0] UNLOCK1_ADDR = 21'h000555;
  localparam logic [ADDR_W-1:0] UNLOCK2_ADDR = 21'h0002aa;
  localparam logic [DATA_W-1:0] UNLOCK1_DATA = 16'h00aa;
  localparam logic [DATA_W-1:0] UNLOCK2_DATA = 16'h0055;
  localparam logic [DATA_W-1:0] ASEL_DATA = 16'h0090;
  localparam logic [DATA_W-1:0] EXIT_DATA = 16'h00f0;
  // ==========================================================================
  // autoselect low address codes (A7..A0), other low bits driven zero
  localparam logic [7:0] CODE_MANUF = 8'h00;
  localparam logic [7:0] CODE_DEV1 = 8'h01;
  localparam logic [7:0] CODE_DEV2 = 8'h0e;
  localparam logic [7:0] CODE_DEV3 = 8'h0f;
  localparam logic [7:0] CODE_PROT = 8'h02;
  localparam logic [7:0] CODE_SECURE = 8'h03;
  // the indicator read must carry a bank address inside a fixed window, past the small boot sectors
  localparam logic [ADDR_W-1:0] SECURE_BA_ADDR = 21'h004000;
  localparam int FACT_LOCK_BIT = 7;
  localparam int CUST_LOCK_BIT = 6;
  // ==========================================================================
  // operations and entry methods
  typedef enum logic [2:0] {
    OP_MANUF, OP_DEVID, OP_PROT, OP_SECURE, OP_ARRAY
  } fas_op_e;
  localparam logic METH_CMD = 1'b0;
  localparam logic METH_HV = 1'b1;
endpackage : fas_pkg
`default_nettype wire

// File: fas_sync.sv
// fas_sync: two-flop synchroniser for a bus of pin inputs.
// assumes each bit is sampled only when it has been stable for several cycles.
`timescale 1ns/10ps
`default_nettype none
module fas_sync #(
  parameter int W = 16
) (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_r;
  // ==========================================================================
  // first stage read only by the second
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_r <= '0;
      q_o <= '0;
    end else begin
      meta_r <= d_i;
      q_o <= meta_r;
    end
  end
endmodule // fas_sync
`default_nettype wire

// File: fas_ctrl.sv
// fas_ctrl: host controller that reads identification and protection codes from a parallel flash.
// assumes the flash pins are wired directly, and a board switch applies the high id level on A9
// while FL_ID_HV_EN_O is high.
`timescale 1ns/10ps
`default_nettype none
// Function
// RULE1: device returns codes on low byte
// RULE2: hold high id level on A9
// RULE3: A10, A8, A5-A4 are don't care
// RULE4: sector query: A1 high, A0 low
// RULE5: enter autoselect by command sequence instead
// RULE6: bank in third write selects bank
// RULE7: manufacturer at 0, device at 1,e,f
// RULE8: secured indicator: A1,A0 high, bits 7/6
// RULE9: secured region split in two 64-word areas
// RULE10: top bank: 32K sector then eight 4K
// RULE11: third bank uniform 32K sectors
// RULE12: other banks and after exit: array data
module fas_ctrl (
  input wire logic MCLK_I,
  input wire logic RST_N_I,
  input wire logic CMD_VALID_I,
  output logic CMD_READY_O,
  input wire logic [2:0] CMD_OP_I,
  input wire logic CMD_METHOD_I,
  input wire logic [20:0] CMD_ADDR_I,
  output logic RSP_VALID_O,
  output logic [47:0] RSP_DATA_O,
  output logic RSP_PROT_O,
  output logic RSP_FACT_LOCK_O,
  output logic RSP_CUST_LOCK_O,
  output logic [20:0] FL_ADDR_O,
  output logic FL_CE_N_O,
  output logic FL_OE_N_O,
  output logic FL_WE_N_O,
  input wire logic [15:0] FL_DQ_I,
  output logic [15:0] FL_DQ_O,
  output logic FL_DQ_OE_N_O,
  output logic FL_ID_HV_EN_O
);
  typedef enum logic [2:0] {ST_IDLE, ST_LOAD, ST_HV, ST_WR, ST_RD, ST_GAP, ST_RSP} fas_state_e;
  localparam int AW = fas_pkg::ADDR_W;
  localparam int DW = fas_pkg::DATA_W;

  fas_state_e state_r, state_nxt;
  logic [2:0] step_r, step_nxt;
  logic [7:0] cnt_r, cnt_nxt;
  fas_pkg::fas_op_e op_r;
  logic meth_r;
  logic [AW-1:0] caddr_r;
  logic [47:0] words_r;
  logic [DW-1:0] dq_sync;
  logic [AW-1:0] addr_r;
  logic [DW-1:0] dq_r;
  logic ce_n_r, oe_n_r, we_n_r, dq_oe_n_r, hv_r;
  logic rsp_valid_r, prot_r, fact_r, cust_r;

  // ==========================================================================
  // data pins come from outside the clock domain
  fas_sync #(.W(DW)) u_sync (
    .mclk_i(MCLK_I),
    .rst_n_i(RST_N_I),
    .d_i(FL_DQ_I),
    .q_o(dq_sync)
  );

  // ==========================================================================
  // step plan: unlock writes, reads, exit write
  wire is_asel = (op_r != fas_pkg::OP_ARRAY);
  wire use_cmd = is_asel && (meth_r == fas_pkg::METH_CMD); // RULE5
  wire [2:0] n_wr = use_cmd ? 3'h3 : 3'h0;
  wire [2:0] n_rd = (op_r == fas_pkg::OP_DEVID) ? 3'h3 : 3'h1;
  wire [2:0] n_ex = use_cmd ? 3'h1 : 3'h0;
  wire [2:0] last_step = 3'(n_wr + n_rd + n_ex - 3'h1);
  wire is_wr_n = (step_nxt < n_wr) || ((n_ex != 3'h0) && (step_nxt == 3'(n_wr + n_rd)));
  wire [1:0] rd_idx_n = 2'(step_nxt - n_wr);
  wire is_wr_c = (step_r < n_wr) || ((n_ex != 3'h0) && (step_r == 3'(n_wr + n_rd)));

  // ==========================================================================
  // address decode for the coming step
  // the bank field leads so one bank is in autoselect and the rest read array data
  // the secured indicator uses a fixed in-window bank address, whatever the caller gave
  wire [AW-1:0] op_addr = (op_r == fas_pkg::OP_SECURE) ? fas_pkg::SECURE_BA_ADDR : caddr_r; // RULE8
  wire [AW-1:0] bank_base = {op_addr[AW-1:fas_pkg::BANK_LSB], 18'h00000};
  wire [AW-1:0] sect_base = {caddr_r[AW-1:fas_pkg::SECT_LSB], 12'h000};
  // sector field A20..A12 covers the 32K sectors of the third bank (low three bits
  // then unused) and the 4K sectors of the top bank, so any word address works
  wire [7:0] dev_code = (rd_idx_n == 2'h0) ? fas_pkg::CODE_DEV1 :
                        (rd_idx_n == 2'h1) ? fas_pkg::CODE_DEV2 : fas_pkg::CODE_DEV3; // RULE7
  // A10, A9, A8 and A5..A4 are left low; the switch overdrives A9 in high voltage mode
  wire [7:0] rd_code = (op_r == fas_pkg::OP_MANUF) ? fas_pkg::CODE_MANUF :  // RULE7
                       (op_r == fas_pkg::OP_DEVID) ? dev_code :
                       (op_r == fas_pkg::OP_PROT) ? fas_pkg::CODE_PROT :     // RULE4
                       fas_pkg::CODE_SECURE;                                 // RULE8
  wire [AW-1:0] rd_addr = (op_r == fas_pkg::OP_ARRAY) ? caddr_r :           // RULE12
                          (op_r == fas_pkg::OP_PROT) ? (sect_base | {13'h0000, rd_code}) :
                          (op_r == fas_pkg::OP_SECURE) ? (op_addr | {13'h0000, rd_code}) : // RULE8
                          (bank_base | {13'h0000, rd_code});                 // RULE3
  wire [AW-1:0] wr_addr = (step_nxt == 3'h0) ? fas_pkg::UNLOCK1_ADDR :
                          (step_nxt == 3'h1) ? fas_pkg::UNLOCK2_ADDR :
                          (bank_base | fas_pkg::UNLOCK1_ADDR);               // RULE6
  wire [DW-1:0] wr_data = (step_nxt == 3'h0) ? fas_pkg::UNLOCK1_DATA :
                          (step_nxt == 3'h1) ? fas_pkg::UNLOCK2_DATA :
                          (step_nxt == 3'h2) ? fas_pkg::ASEL_DATA : fas_pkg::EXIT_DATA; // RULE12

  // ==========================================================================
  // sequencer
  always_comb begin
    state_nxt = state_r;
    step_nxt = step_r;
    cnt_nxt = (cnt_r != 8'h00) ? 8'(cnt_r - 8'h01) : 8'h00;
    unique case (state_r)
      ST_IDLE: begin
        step_nxt = 3'h0;
        if (CMD_VALID_I) begin
          state_nxt = ST_LOAD;
        end
      end
      ST_LOAD: begin
        if (is_asel && meth_r == fas_pkg::METH_HV) begin
          state_nxt = ST_HV;
          cnt_nxt = 8'(fas_pkg::T_HV_CYC - 1);
        end else begin
          state_nxt = is_wr_n ? ST_WR : ST_RD;
          cnt_nxt = is_wr_n ? 8'(fas_pkg::T_WP_CYC - 1) : 8'(fas_pkg::T_ACC_CYC - 1);
        end
      end
      ST_HV: begin
        if (cnt_r == 8'h00) begin
          state_nxt = ST_RD;
          cnt_nxt = 8'(fas_pkg::T_ACC_CYC - 1);
        end
      end
      ST_WR, ST_RD: begin
        if (cnt_r == 8'h00) begin
          state_nxt = ST_GAP;
          cnt_nxt = 8'(fas_pkg::T_GAP_CYC - 1);
        end
      end
      ST_GAP: begin
        if (cnt_r == 8'h00) begin
          if (step_r == last_step) begin
            state_nxt = ST_RSP;
          end else begin
            step_nxt = 3'(step_r + 3'h1);
            state_nxt = is_wr_n ? ST_WR : ST_RD;
            cnt_nxt = is_wr_n ? 8'(fas_pkg::T_WP_CYC - 1) : 8'(fas_pkg::T_ACC_CYC - 1);
          end
        end
      end
      ST_RSP: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // ==========================================================================
  // pin next values, all registered so the flash sees clean edges
  wire cyc_n = (state_nxt == ST_WR) || (state_nxt == ST_RD);
  wire drive_n = (state_nxt == ST_WR) || ((state_nxt == ST_GAP) && is_wr_c); // hold data past WE rise
  // the op is only latched on entry to load, so the level waits for the settle state
  wire hv_n = (state_nxt != ST_IDLE) && (state_nxt != ST_LOAD) && (state_nxt != ST_RSP) && is_asel &&
              (meth_r == fas_pkg::METH_HV);                                  // RULE2
  wire [AW-1:0] addr_n = (state_nxt == ST_WR) ? wr_addr :
                         (state_nxt == ST_RD || state_nxt == ST_HV) ? rd_addr : addr_r;
  wire capture = (state_r == ST_RD) && (cnt_r == 8'h00);

  // ==========================================================================
  // state and command latch
  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      state_r <= ST_IDLE;
      step_r <= 3'h0;
      cnt_r <= 8'h00;
      op_r <= fas_pkg::OP_MANUF;
      meth_r <= fas_pkg::METH_CMD;
      caddr_r <= '0;
    end else begin
      state_r <= state_nxt;
      step_r <= step_nxt;
      cnt_r <= cnt_nxt;
      if (state_r == ST_IDLE && CMD_VALID_I) begin
        op_r <= fas_pkg::fas_op_e'(CMD_OP_I);
        meth_r <= CMD_METHOD_I;
        caddr_r <= CMD_ADDR_I;
      end
    end
  end

  // ==========================================================================
  // flash pins
  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      addr_r <= '0;
      dq_r <= '0;
      ce_n_r <= 1'b1;
      oe_n_r <= 1'b1;
      we_n_r <= 1'b1;
      dq_oe_n_r <= 1'b1;
      hv_r <= 1'b0;
    end else begin
      addr_r <= addr_n;
      dq_r <= (state_nxt == ST_WR) ? wr_data : dq_r;
      ce_n_r <= !cyc_n;
      oe_n_r <= !(state_nxt == ST_RD);
      we_n_r <= !(state_nxt == ST_WR);
      dq_oe_n_r <= !drive_n;
      hv_r <= hv_n;
    end
  end

  // ==========================================================================
  // read capture and answer; codes sit on the low byte except the 16-bit id words
  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      words_r <= '0;
      rsp_valid_r <= 1'b0;
      prot_r <= 1'b0;
      fact_r <= 1'b0;
      cust_r <= 1'b0;
    end else begin
      if (state_r == ST_LOAD) begin
        words_r <= '0;
      end else if (capture) begin
        words_r <= {words_r[31:0], dq_sync};                                // RULE7
      end
      rsp_valid_r <= (state_r == ST_RSP);
      if (state_r == ST_RSP) begin
        prot_r <= (op_r == fas_pkg::OP_PROT) && (words_r[15:0] != 16'h0000); // RULE4
        fact_r <= (op_r == fas_pkg::OP_SECURE) && words_r[fas_pkg::FACT_LOCK_BIT]; // RULE8
        cust_r <= (op_r == fas_pkg::OP_SECURE) && words_r[fas_pkg::CUST_LOCK_BIT]; // RULE1
      end
    end
  end

  assign CMD_READY_O = (state_r == ST_IDLE);
  assign RSP_VALID_O = rsp_valid_r;
  assign RSP_DATA_O = words_r;
  assign RSP_PROT_O = prot_r;
  assign RSP_FACT_LOCK_O = fact_r;
  assign RSP_CUST_LOCK_O = cust_r;
  assign FL_ADDR_O = addr_r;
  assign FL_CE_N_O = ce_n_r;
  assign FL_OE_N_O = oe_n_r;
  assign FL_WE_N_O = we_n_r;
  assign FL_DQ_O = dq_r;
  assign FL_DQ_OE_N_O = dq_oe_n_r;
  assign FL_ID_HV_EN_O = hv_r;
endmodule // fas_ctrl
`default_nettype wire

// File: fas_ctrl_sva.sv
// fas_ctrl_sva: pin and response checks for fas_ctrl.
// assumes it is bound to fas_ctrl and sees only its ports.
`timescale 1ns/10ps
`default_nettype none
module fas_ctrl_sva (
  input wire logic MCLK_I,
  input wire logic RST_N_I,
  input wire logic RSP_VALID_O,
  input wire logic [47:0] RSP_DATA_O,
  input wire logic RSP_PROT_O,
  input wire logic RSP_FACT_LOCK_O,
  input wire logic RSP_CUST_LOCK_O,
  input wire logic [20:0] FL_ADDR_O,
  input wire logic FL_CE_N_O,
  input wire logic FL_OE_N_O,
  input wire logic FL_WE_N_O,
  input wire logic FL_DQ_OE_N_O,
  input wire logic FL_ID_HV_EN_O
);
  // ==========================================================================
  // one clock domain, so clock and reset are given once
  default clocking @(posedge MCLK_I); endclocking
  default disable iff (!RST_N_I);
  property p_hv_read; !FL_OE_N_O && FL_ID_HV_EN_O |-> !FL_ADDR_O[9] && !FL_ADDR_O[6]; endproperty
  a_hv_read: assert property (p_hv_read) else $error("high level read with bad address");
  property p_hv_no_wr; FL_ID_HV_EN_O |-> FL_WE_N_O; endproperty
  a_hv_no_wr: assert property (p_hv_no_wr) else $error("write while high level applied");
  // the id level must settle before the first read strobe
  property p_hv_settle; $rose(FL_ID_HV_EN_O) |-> FL_OE_N_O[*8]; endproperty
  a_hv_settle: assert property (p_hv_settle) else $error("read before id level settled");
  property p_wr_width; $fell(FL_WE_N_O) |-> !FL_WE_N_O[*4] ##1 FL_WE_N_O; endproperty
  a_wr_width: assert property (p_wr_width) else $error("write pulse length wrong");
  property p_wr_ctl; $fell(FL_WE_N_O) |-> !FL_CE_N_O && FL_OE_N_O && !FL_DQ_OE_N_O; endproperty
  a_wr_ctl: assert property (p_wr_ctl) else $error("write strobe without select or data");
  // bus contention hazard: never drive data while the flash outputs
  property p_rd_ctl; !FL_OE_N_O |-> FL_DQ_OE_N_O && FL_WE_N_O && !FL_CE_N_O; endproperty
  a_rd_ctl: assert property (p_rd_ctl) else $error("read strobe with data driven");
  property p_prot; RSP_VALID_O |-> RSP_PROT_O == 1'b0 || RSP_DATA_O[15:0] != 16'h0; endproperty
  a_prot: assert property (p_prot) else $error("protect flag with zero word");
  property p_lock; RSP_VALID_O && (RSP_FACT_LOCK_O || RSP_CUST_LOCK_O) |->
    RSP_DATA_O[7:6] == {RSP_FACT_LOCK_O, RSP_CUST_LOCK_O}; endproperty
  a_lock: assert property (p_lock) else $error("lock flags differ from word");
  c_hv: cover property ($rose(FL_ID_HV_EN_O));
  c_prot: cover property (RSP_VALID_O && RSP_PROT_O);
  c_lock: cover property (RSP_VALID_O && RSP_CUST_LOCK_O);
endmodule // fas_ctrl_sva
bind fas_ctrl fas_ctrl_sva i_sva (.MCLK_I, .RST_N_I, .RSP_VALID_O, .RSP_DATA_O, .RSP_PROT_O, .RSP_FACT_LOCK_O,
  .RSP_CUST_LOCK_O, .FL_ADDR_O, .FL_CE_N_O, .FL_OE_N_O, .FL_WE_N_O, .FL_DQ_OE_N_O, .FL_ID_HV_EN_O);
`default_nettype wire

// File: fas_flash_model.sv
// fas_flash_model: behavioural x16 flash with autoselect, protect query and array reads.
// assumes the high id level is on A9 whenever hv_i is high.
`timescale 1ns/10ps
`default_nettype none
module fas_flash_model #(
  parameter logic [15:0] MID = 16'h00a5, // arbitrary value
  parameter logic [15:0] D1 = 16'h3c01, // arbitrary value
  parameter logic [15:0] D2 = 16'h3c0e, // arbitrary value
  parameter logic [15:0] D3 = 16'h3c0f // arbitrary value
) (
  input wire logic [20:0] addr_i,
  input wire logic ce_n_i,
  input wire logic oe_n_i,
  input wire logic we_n_i,
  input wire logic [15:0] dq_i,
  input wire logic hv_i,
  input wire logic lock_f_i,
  input wire logic lock_c_i,
  output logic [15:0] dq_o
);
  logic asel_r = 1'b0;
  logic [1:0] step_r = 2'h0;
  logic [2:0] bank_r = 3'h0;
  logic [15:0] val;
  logic [15:0] last_r = 16'h0;
  wire asel = hv_i || (asel_r && addr_i[20:18] == bank_r);
  wire prot = ^((addr_i[20:15] == 6'h3f) ? addr_i[20:12] : {addr_i[20:15], 3'h0});
  wire at555 = addr_i[10:0] == 11'h555;
  // strobe is the overlap of select and write enable: the controller lifts both on one edge
  wire wr_act = (ce_n_i === 1'b0) && (we_n_i === 1'b0);
  // ==========================================================================
  // command decoder, taken as the write strobe ends; bad unlocks start over
  always @(negedge wr_act) begin
    if (dq_i[7:0] == 8'hf0) asel_r <= 1'b0;
    if (step_r == 2'h2 && at555 && dq_i[7:0] == 8'h90) begin
      asel_r <= 1'b1;
      bank_r <= addr_i[20:18];
    end
    step_r <= (at555 && dq_i[7:0] == 8'haa) ? 2'h1 :
      (step_r == 2'h1 && addr_i[10:0] == 11'h2aa && dq_i[7:0] == 8'h55) ? 2'h2 : 2'h0;
  end
  // ==========================================================================
  // read data: codes in autoselect, array contents elsewhere
  always_comb begin
    case ({addr_i[7:6], addr_i[3:0]})
      6'h00: val = MID;
      6'h01: val = D1;
      6'h0e: val = D2;
      6'h0f: val = D3;
      6'h02: val = {15'h0, prot};
      default: val = 16'h0;
    endcase
    // indicator answers only inside its bank window; lock_f guards the 64 factory words
    // at 00-3f, lock_c the 64 customer words just above them
    if ({addr_i[6], addr_i[3:0]} == 5'h03 && addr_i[20:18] == 3'h0 && addr_i[17:14] != 4'h0) begin
      val = {8'h0, lock_f_i, lock_f_i & lock_c_i, 6'h0};
    end
    if (!asel) val = addr_i[15:0] ^ 16'h3c3c;
  end
  // a released bus shows the inverse of the last word, never a stale copy
  always @(posedge oe_n_i) last_r <= val;
  assign #40 dq_o = (!ce_n_i && !oe_n_i) ? val : ~last_r;
endmodule // fas_flash_model
`default_nettype wire

// File: test_flash_autoselect_id_readout.sv
// test_flash_autoselect_id_readout: id, protect, lock and array reads against the flash model.
// assumes fas_pkg, fas_ctrl, the checker and fas_flash_model are compiled first.
`timescale 1ns/10ps
`default_nettype none
module test_flash_autoselect_id_readout;
  logic clk = 0, rst_n = 0, vld = 0, meth = 0, lf = 0, lc = 0;
  logic rdy, rv, rp, rf, rc, ce_n, oe_n, we_n, doe_n, hv;
  logic [2:0] op = 0;
  logic [20:0] adr = 0, fa;
  logic [47:0] rd;
  logic [15:0] dq_m, dq_c;
  int seed = 91, err_count = 0, n_checks = 0, cyc = 0;
  logic [47:0] exp_q[$];
  wire [15:0] dq_w = !doe_n ? dq_c : dq_m;
  always #5 clk = ~clk;
  fas_ctrl i_dut (.MCLK_I(clk), .RST_N_I(rst_n), .CMD_VALID_I(vld), .CMD_READY_O(rdy), .CMD_OP_I(op),
    .CMD_METHOD_I(meth), .CMD_ADDR_I(adr), .RSP_VALID_O(rv), .RSP_DATA_O(rd), .RSP_PROT_O(rp),
    .RSP_FACT_LOCK_O(rf), .RSP_CUST_LOCK_O(rc), .FL_ADDR_O(fa), .FL_CE_N_O(ce_n), .FL_OE_N_O(oe_n),
    .FL_WE_N_O(we_n), .FL_DQ_I(dq_w), .FL_DQ_O(dq_c), .FL_DQ_OE_N_O(doe_n), .FL_ID_HV_EN_O(hv));
  fas_flash_model i_flash (.addr_i(fa), .ce_n_i(ce_n), .oe_n_i(oe_n), .we_n_i(we_n), .dq_i(dq_w),
    .hv_i(hv), .lock_f_i(lf), .lock_c_i(lc), .dq_o(dq_m));
  // ==========================================================================
  // reference: protect status is the parity of the sector number
  function automatic logic sp(input logic [20:0] a);
    return ^((a[20:15] == 6'h3f) ? a[20:12] : {a[20:15], 3'h0});
  endfunction
  task automatic chk(input string nm, input logic [47:0] s, input logic [47:0] x);
    n_checks++;
    if (s !== x) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", nm, x, s);
    end
  endtask
  // one request, held until taken, then the response is compared
  task automatic run(input logic [2:0] o, input logic m, input logic [20:0] a);
    logic [47:0] e;
    int n;
    while (rdy !== 1'b1) @(posedge clk) #1;
    {vld, op, meth, adr} = {1'b1, o, m, a};
    {lf, lc} = 2'($random(seed));
    case (o)
      3'h0: e = {32'h0, i_flash.MID};
      3'h1: e = {i_flash.D1, i_flash.D2, i_flash.D3};
      3'h2: e = {47'h0, sp(a)};
      3'h3: e = {40'h0, lf, lf & lc, 6'h0};
      default: e = {32'h0, a[15:0] ^ 16'h3c3c};
    endcase
    exp_q.push_back(e);
    @(posedge clk) #1;
    vld = 0;
    chk("cmd_ready", {47'h0, rdy}, 48'h0);
    n = 0;
    while (rv !== 1'b1 && n < 400) begin
      @(posedge clk) #1;
      n++;
    end
    chk("rsp_valid", {47'h0, rv}, 48'h1);
    chk("rsp_data", rd, exp_q.pop_front());
    chk("flags", {45'h0, rp, rf, rc}, {45'h0, o == 3'h2 && sp(a), o == 3'h3 && lf, o == 3'h3 && lf && lc});
    $display("test op %0d method %0d done", o, m);
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // ==========================================================================
  // every op by both methods, a 4K and a 32K sector, then random traffic
  initial begin
    repeat (10) @(posedge clk);
    #1 rst_n = 1;
    for (int i = 0; i < 10; i++) run(3'(i / 2), 1'(i % 2), 21'($random(seed)));
    run(3'h2, 1'b0, 21'h1fa000);
    run(3'h2, 1'b1, 21'h1ef000);
    for (int i = 0; i < 30; i++) run(3'($unsigned($random(seed)) % 5), 1'($random(seed)), 21'($random(seed)));
    results();
  end
  // hang guard well above the longest expected run
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      results();
    end
  end
endmodule // test_flash_autoselect_id_readout
`default_nettype wire
